// ===== rtl/rssc_top.v
// reset, start-up and synchronisation control with an APB register slave
// Function
// - Power-on, long pin low and serial command all reset; converter off.
// - After power-on interval data-ready rises; earlier serial traffic ignored.
// - Pin held low past threshold resets until the pin returns high.
// - Serial reset command word is 0011h.
// - Reset command in first word acts only when the frame completes.
// - A frame is complete only after five words.
// - Reset at once on latch; host waits acquisition time afterwards.
// - Secondary-fail bit readable by status word or status register read.
// - Secondary-fail latched high at power-up, cleared by first read; here a read leaves it set while the converter is off or its supply down.
// - Data-ready fall marks new data, valid only if no fail in period.
// - Pin or command reset clears enable; start-up without supply ramp.
// - Low pulse between one main-clock period and threshold synchronises.
// - Main clock resuming re-enables converter; registers are kept.
// - Sync edge compared to data-rate clock; misaligned resets filters.
// - Global-chop mode restarts conversions on every sync falling edge.
// - Phase settings survive sync; results settle after three conversions.
// - Global-chop mode also restarts conversions on a ratio change.
//
// Chosen here: the APB slave port and the placing of the registers.
`include "rssc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rssc_top #(
    parameter POR_TIME_NS = `RSSC_POR_TIME_NS,
    parameter RSL_TIME_NS = `RSSC_RSL_TIME_NS
) (
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire SYNC_RESET_N,
    input wire MAIN_CLOCK_IN,
    input wire SEC_SUPPLY_OK,
    input wire [15:0] FRAME_WORD,
    input wire FRAME_WORD_STB,
    input wire FRAME_END,
    input wire STATUS_WORD_STB,
    output reg DATA_READY_OUTPUT,
    output reg SERIAL_READY,
    output reg ISO_CONVERTER_ENABLE,
    output reg [3:0] ISO_CONVERTER_FREQ,
    output reg [1:0] CLOCK_DIVIDER,
    output reg DATA_VALID,
    output reg FILTER_RESET,
    output reg [2:0] CH_SETTLED
);
    localparam CLK_NS = `RSSC_CLK_PERIOD_NS;
    localparam POR_CYC = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam RSL_CYC = RSL_TIME_NS / CLK_NS;
    localparam ACQ_CYC = (`RSSC_REGACQ_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam PAUSE_CYC = `RSSC_PAUSE_TIME_NS / CLK_NS;
    localparam [1:0] ST_POR = 2'h0;
    localparam [1:0] ST_PINRST = 2'h1;
    localparam [1:0] ST_ACQ = 2'h2;
    localparam [1:0] ST_RUN = 2'h3;

    wire pin_lvl;
    wire pin_fall;
    wire pin_rise;
    wire mclk_rise;
    wire sec_ok;

    rssc_pin_sync #(.INIT(1'b1)) u_pin_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .din(SYNC_RESET_N),
        .q(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    rssc_pin_sync #(.INIT(1'b0)) u_mclk_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .din(MAIN_CLOCK_IN),
        .q(),
        .rise(mclk_rise),
        .fall()
    );
    rssc_pin_sync #(.INIT(1'b0)) u_sec_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .din(SEC_SUPPLY_OK),
        .q(sec_ok),
        .rise(),
        .fall()
    );

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [19:0] timer_ff;
    reg [19:0] low_cnt_ff;
    reg mclk_seen_ff;
    reg aligned_ff;
    reg [2:0] frame_cnt_ff;
    reg first_reset_ff;
    reg cmd_reset;
    reg [31:0] ctrl_ff;
    reg [23:0] phase_ff;
    reg secfail_ff;
    reg [15:0] idle_cnt_ff;
    reg [15:0] rate_cnt_ff;
    reg [2:0] osr_prev_ff;
    reg period_fail_ff;

    wire running = (state_ff == ST_RUN);
    wire apb_acc = PSEL & PENABLE;
    wire apb_wr = apb_acc & PWRITE & running;
    wire is_ctrl = (PADDR == `RSSC_ADDR_CTRL);
    wire is_stat = (PADDR == `RSSC_ADDR_STATUS);
    wire is_phase = (PADDR == `RSSC_ADDR_PHASE);
    wire mapped = is_ctrl | is_stat | is_phase;
    wire en_bit = ctrl_ff[`RSSC_CTRL_EN_BIT];
    wire gc_mode = ctrl_ff[`RSSC_CTRL_GC_BIT];
    wire [2:0] osr_code = ctrl_ff[`RSSC_CTRL_OSR_MSB:`RSSC_CTRL_OSR_LSB];
    wire [15:0] osr_len = `RSSC_OSR_BASE << osr_code;
    wire mclk_run = (idle_cnt_ff < PAUSE_CYC[15:0]);
    wire conv_on = running & en_bit & mclk_run & sec_ok;
    wire live_fail = ~sec_ok | ~ISO_CONVERTER_ENABLE;
    wire stat_read = (apb_acc & ~PWRITE & is_stat) | (STATUS_WORD_STB & running);
    wire cfg_clear = ~running | cmd_reset;
    wire pin_long = ~pin_lvl & (low_cnt_ff > RSL_CYC[19:0]);
    wire sync_pulse = pin_rise & running & mclk_seen_ff & ~pin_long;
    wire gc_restart = running & gc_mode &
        (pin_fall | (osr_code != osr_prev_ff));
    wire wrap = conv_on & mclk_rise & (rate_cnt_ff == osr_len - 16'h0001);
    wire restart = gc_restart | (sync_pulse & ~gc_mode & ~aligned_ff);

    assign PREADY = 1'b1;
    assign PSLVERR = apb_acc & ~mapped;

    // no serial frame can bypass the sequence; a command reset is a pulse
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR: begin
                if (timer_ff >= POR_CYC[19:0] - 20'h00001)
                    nxt_state = ST_RUN;
            end
            ST_PINRST: begin
                if (pin_lvl)
                    nxt_state = ST_ACQ;
            end
            ST_ACQ: begin
                if (pin_long)
                    nxt_state = ST_PINRST;
                else if (timer_ff >= ACQ_CYC[19:0] - 20'h00001)
                    nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (pin_long)
                    nxt_state = ST_PINRST;
                else if (cmd_reset)
                    nxt_state = ST_ACQ;
            end
            default: nxt_state = ST_POR;
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            state_ff <= ST_POR;
            timer_ff <= 20'h00000;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                timer_ff <= 20'h00000;
            else if (timer_ff != 20'hFFFFF)
                timer_ff <= timer_ff + 20'h00001;
        end
    end

    // pulse width measured in system cycles; a main-clock edge during the low pulse is flagged, not counted
    always @(posedge CLK_SYS) begin
        if (RST) begin
            low_cnt_ff <= 20'h00000;
            mclk_seen_ff <= 1'b0;
            aligned_ff <= 1'b0;
        end else if (pin_lvl) begin
            low_cnt_ff <= 20'h00000;
            if (!pin_rise)
                mclk_seen_ff <= 1'b0;
        end else begin
            if (low_cnt_ff != 20'hFFFFF)
                low_cnt_ff <= low_cnt_ff + 20'h00001;
            if (mclk_rise)
                mclk_seen_ff <= 1'b1;
            if (pin_fall)
                aligned_ff <= (rate_cnt_ff == 16'h0000);
        end
    end

    // frame tracking for the serial reset command
    always @(posedge CLK_SYS) begin
        if (RST || !running) begin
            frame_cnt_ff <= 3'h0;
            first_reset_ff <= 1'b0;
            cmd_reset <= 1'b0;
        end else begin
            cmd_reset <= 1'b0;
            if (FRAME_END) begin
                frame_cnt_ff <= 3'h0;
                first_reset_ff <= 1'b0;
                if (first_reset_ff && frame_cnt_ff >= `RSSC_FRAME_WORDS)
                    cmd_reset <= 1'b1;
            end else if (FRAME_WORD_STB) begin
                if (frame_cnt_ff == 3'h0)
                    first_reset_ff <= (FRAME_WORD == `RSSC_RESET_CMD);
                if (frame_cnt_ff != `RSSC_FRAME_WORDS)
                    frame_cnt_ff <= frame_cnt_ff + 3'h1;
            end
        end
    end

    // configuration; writes refused until the serial side is ready
    always @(posedge CLK_SYS) begin
        if (RST || cfg_clear) begin
            ctrl_ff <= `RSSC_CTRL_RESET;
            phase_ff <= `RSSC_PHASE_RESET;
        end else if (apb_wr) begin
            if (is_ctrl)
                ctrl_ff <= PWDATA;
            if (is_phase)
                phase_ff <= PWDATA[23:0];
        end
    end

    // latched fail flag: hardware set wins over the read clear
    always @(posedge CLK_SYS) begin
        if (RST || cfg_clear)
            secfail_ff <= 1'b1;
        else if (live_fail && ISO_CONVERTER_ENABLE)
            secfail_ff <= 1'b1;
        else if (stat_read)
            secfail_ff <= live_fail;
    end

    // pause detection on the sampled main clock
    always @(posedge CLK_SYS) begin
        if (RST)
            idle_cnt_ff <= PAUSE_CYC[15:0];
        else if (mclk_rise)
            idle_cnt_ff <= 16'h0000;
        else if (idle_cnt_ff < PAUSE_CYC[15:0])
            idle_cnt_ff <= idle_cnt_ff + 16'h0001;
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            ISO_CONVERTER_ENABLE <= 1'b0;
            ISO_CONVERTER_FREQ <= 4'h0;
            CLOCK_DIVIDER <= 2'h0;
            SERIAL_READY <= 1'b0;
        end else begin
            // register kept across a pause, so the converter comes back
            ISO_CONVERTER_ENABLE <= running & (nxt_state == ST_RUN) &
                en_bit & mclk_run;
            ISO_CONVERTER_FREQ <=
                ctrl_ff[`RSSC_CTRL_FREQ_MSB:`RSSC_CTRL_FREQ_LSB];
            CLOCK_DIVIDER <= ctrl_ff[`RSSC_CTRL_DIV_MSB:`RSSC_CTRL_DIV_LSB];
            SERIAL_READY <= (nxt_state == ST_RUN);
        end
    end

    // data-rate clock in main-clock edges; data_ready_output low for the first half
    always @(posedge CLK_SYS) begin
        if (RST) begin
            rate_cnt_ff <= 16'h0000;
            osr_prev_ff <= 3'h0;
            period_fail_ff <= 1'b1;
            DATA_READY_OUTPUT <= 1'b0;
            DATA_VALID <= 1'b0;
            FILTER_RESET <= 1'b0;
        end else begin
            osr_prev_ff <= osr_code;
            FILTER_RESET <= restart;
            if (!running) begin
                rate_cnt_ff <= 16'h0000;
                period_fail_ff <= 1'b1;
                DATA_READY_OUTPUT <= (nxt_state == ST_RUN);
                DATA_VALID <= 1'b0;
            end else if (restart) begin
                rate_cnt_ff <= 16'h0000;
                period_fail_ff <= secfail_ff;
                DATA_READY_OUTPUT <= 1'b1;
            end else begin
                if (secfail_ff)
                    period_fail_ff <= 1'b1;
                if (wrap) begin
                    rate_cnt_ff <= 16'h0000;
                    DATA_READY_OUTPUT <= 1'b0;
                    DATA_VALID <= ~period_fail_ff & ~secfail_ff;
                    period_fail_ff <= secfail_ff;
                end else if (conv_on && mclk_rise) begin
                    rate_cnt_ff <= rate_cnt_ff + 16'h0001;
                    if (rate_cnt_ff == (osr_len >> 1))
                        DATA_READY_OUTPUT <= 1'b1;
                end else if (!conv_on) begin
                    DATA_READY_OUTPUT <= 1'b1;
                end
            end
        end
    end

    // per-channel settling; phase settings untouched by a restart
    genvar ch;
    generate
        for (ch = 0; ch < `RSSC_NUM_CH; ch = ch + 1) begin : g_ch
            reg [1:0] conv_cnt_ff;
            always @(posedge CLK_SYS) begin
                if (RST || !running || restart) begin
                    conv_cnt_ff <= 2'h0;
                    CH_SETTLED[ch] <= 1'b0;
                end else begin
                    if (wrap && conv_cnt_ff != `RSSC_SETTLE_CONV)
                        conv_cnt_ff <= conv_cnt_ff + 2'h1;
                    CH_SETTLED[ch] <= (conv_cnt_ff == `RSSC_SETTLE_CONV);
                end
            end
        end
    endgenerate

    // read data staged in the setup phase, so zero wait states
    always @(posedge CLK_SYS) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h0000_0000;
            if (is_ctrl)
                PRDATA <= ctrl_ff;
            else if (is_phase)
                PRDATA <= {8'h00, phase_ff};
            else if (is_stat) begin
                PRDATA[`RSSC_STAT_SECFAIL_BIT] <= secfail_ff;
                PRDATA[`RSSC_STAT_READY_BIT] <= SERIAL_READY;
                PRDATA[`RSSC_STAT_MCLK_BIT] <= mclk_run;
                PRDATA[`RSSC_STAT_DVALID_BIT] <= DATA_VALID;
                PRDATA[`RSSC_STAT_SETTLED_LSB+2:`RSSC_STAT_SETTLED_LSB]
                    <= CH_SETTLED;
            end
        end
    end
endmodule // rssc_top
`default_nettype wire

// ===== pkg/rssc_regs.vh
// register map, field positions, reset values and timing constants
`ifndef RSSC_REGS_VH
`define RSSC_REGS_VH
`define RSSC_ADDR_CTRL 8'h00
`define RSSC_ADDR_STATUS 8'h04
`define RSSC_ADDR_PHASE 8'h08
`define RSSC_CTRL_EN_BIT 0
`define RSSC_CTRL_FREQ_LSB 4
`define RSSC_CTRL_FREQ_MSB 7
`define RSSC_CTRL_DIV_LSB 8
`define RSSC_CTRL_DIV_MSB 9
`define RSSC_CTRL_GC_BIT 10
`define RSSC_CTRL_OSR_LSB 12
`define RSSC_CTRL_OSR_MSB 14
`define RSSC_CTRL_RESET 32'h0000_3000
`define RSSC_PHASE_RESET 24'h00_0000
`define RSSC_STAT_SECFAIL_BIT 0
`define RSSC_STAT_READY_BIT 1
`define RSSC_STAT_MCLK_BIT 2
`define RSSC_STAT_DVALID_BIT 3
`define RSSC_STAT_SETTLED_LSB 4
`define RSSC_RESET_CMD 16'h0011
`define RSSC_FRAME_WORDS 3'h5
`define RSSC_OSR_BASE 16'h0080
`define RSSC_SETTLE_CONV 2'h3
`define RSSC_NUM_CH 3
`define RSSC_CLK_PERIOD_NS 25
`define RSSC_POR_TIME_NS 100000
`define RSSC_RSL_TIME_NS 100000
`define RSSC_REGACQ_TIME_NS 5000
`define RSSC_PAUSE_TIME_NS 2000
`endif

// ===== rtl/rssc_pin_sync.v
// two-flop synchroniser with edge pulses for an asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module rssc_pin_sync #(
    parameter INIT = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire din,
    output wire q,
    output wire rise,
    output wire fall
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    always @(posedge clk) begin
        if (rst) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
            last_ff <= INIT;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign q = sync_ff;
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;
endmodule // rssc_pin_sync
`default_nettype wire

// ===== testbench/rssc_properties.sv
// bound assertions for the reset, start-up and sync controller
`timescale 1ns/1ps
`default_nettype none
module rssc_props #(
    parameter POR_TIME_NS = 2000,
    parameter RSL_TIME_NS = 2000
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SYNC_RESET_N,
    input wire logic [15:0] FRAME_WORD,
    input wire logic FRAME_WORD_STB,
    input wire logic FRAME_END,
    input wire logic SERIAL_READY,
    input wire logic ISO_CONVERTER_ENABLE,
    input wire logic FILTER_RESET
);
    localparam int POR_CYC = POR_TIME_NS / 25;
    localparam int RSL_CYC = RSL_TIME_NS / 25;
    logic [15:0] age_ff;
    logic [15:0] low_ff;
    logic [15:0] first_ff;
    logic [2:0] words_ff;
    // raw pin count; margins below absorb the design's two-flop delay
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            age_ff <= 16'h0;
            low_ff <= 16'h0;
        end else begin
            age_ff <= (age_ff == 16'hFFFF) ? age_ff : age_ff + 16'h1;
            low_ff <= SYNC_RESET_N ? 16'h0 : low_ff + 16'h1;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST || FRAME_END) begin
            words_ff <= 3'h0;
        end else if (FRAME_WORD_STB && words_ff != 3'h7) begin
            words_ff <= words_ff + 3'h1;
            if (words_ff == 3'h0) first_ff <= FRAME_WORD;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_rst_quiet;
        $fell(RST) |-> !SERIAL_READY && !ISO_CONVERTER_ENABLE;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active right after reset");
    property p_por_hold;
        age_ff < POR_CYC - 2 |-> !SERIAL_READY;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("serial ready before power-on interval");
    property p_por_done;
        age_ff == POR_CYC + 4 |-> SERIAL_READY;
    endproperty
    a_por_done: assert property (p_por_done)
        else $error("serial ready late after power-on");
    property p_cmd;
        FRAME_END && SERIAL_READY && words_ff >= 3'h5
            && first_ff == 16'h0011 |-> ##2 !SERIAL_READY;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("reset command not executed");
    property p_early;
        FRAME_END && SERIAL_READY && words_ff < 3'h5 |-> ##2 SERIAL_READY;
    endproperty
    a_early: assert property (p_early)
        else $error("short frame acted on");
    property p_pin_rst;
        low_ff == RSL_CYC + 8 |-> !SERIAL_READY;
    endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("long pin low did not reset");
    property p_en_run;
        ISO_CONVERTER_ENABLE |-> SERIAL_READY;
    endproperty
    a_en_run: assert property (p_en_run)
        else $error("converter enabled outside run");
    property p_fr_pulse;
        FILTER_RESET |=> !FILTER_RESET;
    endproperty
    a_fr_pulse: assert property (p_fr_pulse)
        else $error("filter reset wider than one cycle");
    c_cmd: cover property (FRAME_END && words_ff == 3'h5);
    c_pin: cover property (low_ff == RSL_CYC + 8);
    c_fr: cover property (FILTER_RESET);
endmodule // rssc_props
bind rssc_top rssc_props #(.POR_TIME_NS(POR_TIME_NS),
    .RSL_TIME_NS(RSL_TIME_NS)) u_props (.CLK_SYS, .RST, .SYNC_RESET_N,
    .FRAME_WORD, .FRAME_WORD_STB, .FRAME_END, .SERIAL_READY,
    .ISO_CONVERTER_ENABLE, .FILTER_RESET);
`default_nettype wire

// ===== testbench/rssc_far_model.sv
// far side: main clock source and isolated secondary supply
`timescale 1ns/1ps
`default_nettype none
module rssc_far_model (
    input wire logic clk_sys,
    input wire logic clk_run,
    input wire logic conv_en,
    output logic mclk,
    output logic sec_ok
);
    logic [5:0] ramp_ff = 6'h0;
    // free phase against the system clock; stands still while paused
    initial begin
        mclk = 1'b0;
        #37;
        forever begin
            #100;
            if (clk_run) mclk = ~mclk;
        end
    end
    // supply collapses at once when the converter stops
    always_ff @(posedge clk_sys) begin
        if (!conv_en) ramp_ff <= 6'h0;
        else if (ramp_ff != 6'h3F) ramp_ff <= ramp_ff + 6'h1;
    end
    assign sec_ok = (ramp_ff == 6'h3F);
endmodule // rssc_far_model
`default_nettype wire

// ===== testbench/reset_sync_startup_control_tb.sv
// self-checking bench for the reset, start-up and sync controller
`timescale 1ns/1ps
`default_nettype none
`include "rssc_regs.vh"
module reset_sync_startup_control_tb;
    logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, SYNC_RESET_N, MAIN_CLOCK_IN;
    logic SEC_SUPPLY_OK, FRAME_WORD_STB, FRAME_END, STATUS_WORD_STB, run;
    logic PREADY, PSLVERR, DATA_READY_OUTPUT, SERIAL_READY, DATA_VALID;
    logic ISO_CONVERTER_ENABLE, FILTER_RESET, slverr;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, q, ctrl, seed, ph;
    logic [15:0] FRAME_WORD;
    logic [3:0] ISO_CONVERTER_FREQ;
    logic [1:0] CLOCK_DIVIDER;
    logic [2:0] CH_SETTLED;
    int err_total = 0, check_count = 0, n, fr_cnt = 0, fr0;
    rssc_top #(.POR_TIME_NS(2000), .RSL_TIME_NS(2000)) dut_u (.CLK_SYS,
        .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .SYNC_RESET_N, .MAIN_CLOCK_IN, .SEC_SUPPLY_OK,
        .FRAME_WORD, .FRAME_WORD_STB, .FRAME_END, .STATUS_WORD_STB,
        .DATA_READY_OUTPUT, .SERIAL_READY, .ISO_CONVERTER_ENABLE,
        .ISO_CONVERTER_FREQ, .CLOCK_DIVIDER, .DATA_VALID, .FILTER_RESET,
        .CH_SETTLED);
    rssc_far_model far_u (.clk_sys(CLK_SYS), .clk_run(run),
        .conv_en(ISO_CONVERTER_ENABLE), .mclk(MAIN_CLOCK_IN),
        .sec_ok(SEC_SUPPLY_OK));
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        report_and_stop();
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge CLK_SYS);
            if (PREADY === 1'b1) break;
        end
        if (k == 20) hang();
        q = PRDATA;
        slverr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // 0 serial ready, 1 converter enable, 2 data ready
    task automatic wait_sig(input int w, input logic v, input int lim);
        for (n = 0; n < lim; n++) begin
            if ((w == 0 ? SERIAL_READY : w == 1 ? ISO_CONVERTER_ENABLE
                : DATA_READY_OUTPUT) === v) return;
            @(posedge CLK_SYS);
        end
        hang();
    endtask
    task automatic pulse(input int len);
        SYNC_RESET_N <= 1'b0;
        repeat (len) @(posedge CLK_SYS);
        SYNC_RESET_N <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
    endtask
    task automatic frame(input logic [15:0] w0, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            FRAME_WORD <= (i == 0) ? w0 : rnd();
            FRAME_WORD_STB <= 1'b1;
            @(posedge CLK_SYS);
            FRAME_WORD_STB <= 1'b0;
            @(posedge CLK_SYS);
        end
        FRAME_END <= 1'b1;
        @(posedge CLK_SYS);
        FRAME_END <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
    endtask
    always @(posedge CLK_SYS) if (FILTER_RESET === 1'b1) fr_cnt <= fr_cnt + 1;
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 43'h0;
        {FRAME_WORD, FRAME_WORD_STB, FRAME_END, STATUS_WORD_STB, run} = 20'h0;
        RST = 1'b1;
        SYNC_RESET_N = 1'b1;
        seed = 32'h0001_73FD;
        repeat (5) @(posedge CLK_SYS);
        RST <= 1'b0;
        // write during power-on must be dropped
        apb(1'b1, `RSSC_ADDR_CTRL, 32'h0000_0001);
        chk("ready", 0, SERIAL_READY);
        wait_sig(0, 1'b1, 200);
        chk("data_ready_output", 1, DATA_READY_OUTPUT);
        apb(1'b0, `RSSC_ADDR_CTRL, 0);
        chk("ctrl", `RSSC_CTRL_RESET, q);
        apb(1'b0, 8'h0C, 0);
        chk("slverr", 1, slverr);
        ctrl = (rnd() & 32'h0000_03F0) | 32'h0000_0001;
        apb(1'b1, `RSSC_ADDR_CTRL, ctrl);
        apb(1'b0, `RSSC_ADDR_CTRL, 0);
        chk("ctrl", ctrl, q);
        chk("freq", ctrl[7:4], ISO_CONVERTER_FREQ);
        chk("div", ctrl[9:8], CLOCK_DIVIDER);
        chk("en", 0, ISO_CONVERTER_ENABLE);
        run <= 1'b1;
        wait_sig(1, 1'b1, 300);
        apb(1'b0, `RSSC_ADDR_STATUS, 0);
        chk("latched", 1, q[0]);
        for (n = 1; n < 40 && q[0] !== 1'b0; n++)
            apb(1'b0, `RSSC_ADDR_STATUS, 0);
        chk("fail_clear", 0, q[0]);
        wait_sig(2, 1'b0, 3000);
        chk("valid_first", 0, DATA_VALID);
        wait_sig(2, 1'b1, 3000);
        wait_sig(2, 1'b0, 3000);
        @(posedge CLK_SYS);
        chk("valid", 1, DATA_VALID);
        run <= 1'b0;
        wait_sig(1, 1'b0, 300);
        run <= 1'b1;
        wait_sig(1, 1'b1, 300);
        apb(1'b0, `RSSC_ADDR_CTRL, 0);
        chk("ctrl_kept", ctrl, q);
        repeat (80) @(posedge CLK_SYS);
        STATUS_WORD_STB <= 1'b1;
        @(posedge CLK_SYS);
        STATUS_WORD_STB <= 1'b0;
        apb(1'b0, `RSSC_ADDR_STATUS, 0);
        chk("word_clear", 0, q[0]);
        ph = {8'h00, rnd(), 8'h5A};
        apb(1'b1, `RSSC_ADDR_PHASE, ph);
        // data_ready_output rise leaves the rate counter mid-period, so a sync misaligns
        wait_sig(2, 1'b0, 3000);
        wait_sig(2, 1'b1, 3000);
        fr0 = fr_cnt;
        pulse(20 + rnd() % 30);
        chk("realign", 1, fr_cnt > fr0);
        chk("sync_ready", 1, SERIAL_READY);
        fr0 = fr_cnt;
        apb(1'b1, `RSSC_ADDR_CTRL, ctrl | 32'h0000_0400);
        pulse(20 + rnd() % 30);
        chk("sync_kept", 1, SERIAL_READY);
        chk("gc_restart", 1, fr_cnt > fr0);
        apb(1'b0, `RSSC_ADDR_PHASE, 0);
        chk("phase_kept", ph, q);
        fr0 = fr_cnt;
        apb(1'b1, `RSSC_ADDR_CTRL, ctrl | 32'h0000_1400);
        repeat (5) @(posedge CLK_SYS);
        chk("osr_restart", 1, fr_cnt > fr0);
        for (int i = 0; i < 3; i++) begin
            chk("unsettled", 0, CH_SETTLED);
            wait_sig(2, 1'b0, 3000);
            wait_sig(2, 1'b1, 3000);
        end
        chk("settled", 7, CH_SETTLED);
        frame(`RSSC_RESET_CMD, 4);
        chk("early_end", 1, SERIAL_READY);
        frame(rnd() | 16'h0100, 5);
        chk("other_cmd", 1, SERIAL_READY);
        frame(`RSSC_RESET_CMD, 5);
        chk("cmd_reset", 0, SERIAL_READY);
        chk("cmd_en", 0, ISO_CONVERTER_ENABLE);
        wait_sig(0, 1'b1, 400);
        apb(1'b0, `RSSC_ADDR_CTRL, 0);
        chk("cmd_ctrl", `RSSC_CTRL_RESET, q);
        apb(1'b1, `RSSC_ADDR_CTRL, ctrl);
        wait_sig(1, 1'b1, 300);
        SYNC_RESET_N <= 1'b0;
        repeat (100) @(posedge CLK_SYS);
        chk("pin_reset", 0, SERIAL_READY);
        chk("pin_en", 0, ISO_CONVERTER_ENABLE);
        SYNC_RESET_N <= 1'b1;
        wait_sig(0, 1'b1, 400);
        apb(1'b0, `RSSC_ADDR_CTRL, 0);
        chk("pin_ctrl", `RSSC_CTRL_RESET, q);
        report_and_stop();
    end
endmodule // reset_sync_startup_control_tb
`default_nettype wire
